// ---- dv/pcs_rom_model.sv ----
// program rom model at the far side of the sequencer
// assumes rom_addr launched from mclk, one clock of read latency
`timescale 1ns/1ps
`default_nettype none
module pcs_rom_model (
  input wire logic mclk,
  input wire logic [10:0] rom_addr,
  output logic [13:0] rom_data
);
  // contents are a fixed function of the address so the bench can predict every word
  always_ff @(posedge mclk) begin
    rom_data <= {rom_addr[10:5] ^ 6'h2d, rom_addr[7:0] ^ 8'h5a};
  end
endmodule
`default_nettype wire

// ---- dv/program_counter_sequencer_test.sv ----
// self-checking bench for pcs_sequencer: core commands, register bus, irq sources
// assumes pcs_rom_model at the rom port and a bench-driven core command
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module program_counter_sequencer_test;
  import pcs_pkg::*;
  logic mclk = 0;
  logic nrst = 0;
  logic [5:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [10:0] rom_addr;
  logic [13:0] rom_data;
  pcs_exec_t exec;
  logic [1:0] phase;
  pcs_cmd_t cmd = '{OP_SEQ, 11'h0};
  logic [7:0] tbl_low_data;
  logic tbl_low_we;
  // pins a,b then timer, time base, rtc pulses
  logic [4:0] src = 0;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int c0;
  logic [10:0] a;
  logic [10:0] t;
  logic [13:0] w;
  logic [31:0] d;
  always #4 mclk = ~mclk;
  pcs_sequencer dut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr),
    .rom_data(rom_data), .exec(exec), .phase(phase), .cmd(cmd), .tbl_low_data(tbl_low_data),
    .tbl_low_we(tbl_low_we), .ext_irq_a_pin(src[0]), .ext_irq_b_pin(src[1]), .timer_ovf(src[2]),
    .time_base_tick(src[3]), .rtc_tick(src[4]));
  pcs_rom_model rom (.mclk(mclk), .rom_addr(rom_addr), .rom_data(rom_data));
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // whole run needs a few hundred cycles; the ceiling leaves wide margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  function automatic logic [13:0] rom_word(input logic [10:0] x);
    return {x[10:5] ^ 6'h2d, x[7:0] ^ 8'h5a};
  endfunction
  function automatic logic [10:0] vec(input int k);
    case (k)
      0: return `PCS_VEC_EXT_A;
      1: return `PCS_VEC_EXT_B;
      2: return `PCS_VEC_TIMER;
      3: return `PCS_VEC_TBASE;
      default: return `PCS_VEC_RTC;
    endcase
  endfunction
  // request held until a rising edge that sees waitrequest low; values read right after
  // the edge are the pre-edge ones, since the design updates only by non-blocking assignment
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic next_cyc();
    do begin
      @(posedge mclk);
      #1;
    end while (phase !== 2'h3);
    @(posedge mclk);
    #1;
  endtask
  task automatic issue(input pcs_op_t op, input logic [10:0] tg);
    next_cyc();
    while (exec.valid !== 1'b1) next_cyc();
    a = exec.addr;
    @(posedge mclk);
    cmd <= '{op, tg};
    next_cyc();
    @(posedge mclk);
    cmd <= '{OP_SEQ, 11'h0};
  endtask
  task automatic land(input logic [10:0] x);
    #1;
    chk(exec.valid === 1'b0, "no dummy cycle");
    next_cyc();
    chk(exec.valid === 1'b1 && exec.addr === x && exec.word === rom_word(x), "wrong target");
  endtask
  task automatic seek(input logic [10:0] x);
    c0 = 0;
    while (!(exec.valid === 1'b1 && exec.addr === x) && c0 < 8) begin
      next_cyc();
      c0++;
    end
    chk(c0 < 8, "vector not reached");
  endtask
  task automatic fire(input logic [4:0] m);
    @(posedge mclk);
    src <= src ^ m;
    @(posedge mclk);
    src <= src & 5'h3;
  endtask
  initial begin
    d = $urandom(32'hc3e838c3);
    repeat (4) @(posedge mclk);
    nrst <= 1;
    next_cyc();
    chk(exec.valid === 1'b1 && exec.addr === 11'h0, "reset start");
    for (int i = 0; i < 3; i++) begin
      a = exec.addr;
      c0 = cyc;
      next_cyc();
      chk(cyc - c0 == 4, "cycle length");
      chk(exec.addr === a + 11'h1 && exec.word === rom_word(a + 11'h1), "sequence");
    end
    bus(1'b0, 4'hf, 8'h0, d);
    chk(d === 32'h0, "unmapped read");
    issue(OP_JUMP, 11'h7ff);
    land(11'h7ff);
    next_cyc();
    chk(exec.addr === 11'h0, "pointer wrap");
    t = 11'($urandom);
    issue(OP_CALL, t);
    land(t);
    bus(1'b0, `PCS_IDX_STACK, 8'h0, d);
    chk(d === 32'h1, "stack after call");
    t = a + 11'h1;
    issue(OP_RET, 11'h0);
    land(t);
    issue(OP_SKIP, 11'h0);
    land(a + 11'h2);
    issue(OP_JUMP, 11'h5a0);
    land(11'h5a0);
    t = 11'($urandom);
    bus(1'b1, `PCS_IDX_PC_LOW, t[7:0], d);
    land({3'h5, t[7:0]});
    bus(1'b0, `PCS_IDX_PC_LOW, 8'h0, d);
    chk(d === {24'h0, 8'(t[7:0] + 8'h01)}, "low byte readback");
    for (int k = 0; k < 2; k++) begin
      t = 11'($urandom);
      bus(1'b1, `PCS_IDX_TBL_PTR, t[7:0], d);
      bus(1'b0, `PCS_IDX_TBL_PTR, 8'h0, d);
      chk(d === {24'h0, t[7:0]}, "pointer readback");
      issue(k ? OP_TAB_LAST : OP_TAB_CUR, 11'h0);
      t = {k ? 3'h7 : a[10:8], t[7:0]};
      w = rom_word(t);
      #1;
      chk(exec.valid === 1'b0, "table cycle");
      c0 = 0;
      while (tbl_low_we !== 1'b1 && c0 < 8) begin
        @(posedge mclk);
        #1;
        c0++;
      end
      chk(c0 < 5 && tbl_low_data === w[7:0], "table low byte");
      chk(exec.valid === 1'b1 && exec.addr === a + 11'h1, "held word");
      bus(1'b1, `PCS_IDX_TBL_HIGH, ~w[7:0], d);
      bus(1'b0, `PCS_IDX_TBL_HIGH, 8'h0, d);
      chk(d === {26'h0, w[13:8]}, "table high byte");
    end
    // the last two passes toggle the pins back, so falling edges are exercised too
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, `PCS_IDX_IRQ_CTRL, 8'h80 | (8'h1 << (k % 5)), d);
      fire(5'h1 << (k % 5));
      seek(vec(k % 5));
      bus(1'b0, `PCS_IDX_IRQ_CTRL, 8'h0, d);
      chk(d[7] === 1'b0, "global enable kept");
      bus(1'b0, `PCS_IDX_IRQ_FLAG, 8'h0, d);
      chk(d[k % 5] === 1'b0, "flag kept");
      issue(OP_RETI, 11'h0);
    end
    // both together: lower vector first, other one still pending
    bus(1'b1, `PCS_IDX_IRQ_CTRL, 8'h98, d);
    fire(5'h18);
    seek(`PCS_VEC_TBASE);
    bus(1'b0, `PCS_IDX_IRQ_FLAG, 8'h0, d);
    chk(d[4:3] === 2'b10, "pending rtc");
    for (int i = 0; i < 3; i++) begin
      issue(OP_CALL, 11'h100);
    end
    bus(1'b1, `PCS_IDX_IRQ_CTRL, 8'h90, d);
    repeat (3) begin
      next_cyc();
      chk(exec.addr !== `PCS_VEC_RTC, "taken with full stack");
    end
    issue(OP_RET, 11'h0);
    seek(`PCS_VEC_RTC);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- logic/pcs_sequencer.sv ----
// program counter sequencer: phase generator, fetch/execute pipeline, stack, vectors, table reads
// assumes a synchronous program rom with one cycle of read latency and a core on mclk
// that presents its decoded command for the executing word by the last phase
// Summary of operation
// - four phases of mclk make one instruction cycle
// - next word is fetched while the previous one executes
// - any counter change costs a dummy cycle replacing the prefetched word
// - instruction pointer is 11 bits, 2048 words
// - pointer steps by one after each fetch
// - true skip discards the prefetched word, pointer lands on skip plus two
// - low byte write is a short jump inside the current 256-word page; readable
// - reset clears the pointer so execution starts at zero
// - first external irq vectors to 004
// - second external irq vectors to 008
// - timer overflow irq vectors to 00c
// - time base irq vectors to 010
// - real time clock irq vectors to 014
// - jump and call load all bits from the word, returns from stack top
// - table address is pointer byte with current page or page 7
// - table low byte goes to data memory, six high bits to high byte register
// - high byte register read only, table pointer read/write, loaded before use
// - each table read takes two instruction cycles
// - four-entry return stack, call and irq push, return pops
// - stack full keeps irq pending until a return pops
// - vectoring clears that request flag and the global enable
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_sequencer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [10:0] rom_addr,
  input wire logic [13:0] rom_data,
  output pcs_pkg::pcs_exec_t exec,
  output logic [1:0] phase,
  input wire pcs_pkg::pcs_cmd_t cmd,
  output logic [7:0] tbl_low_data,
  output logic tbl_low_we,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  input wire logic timer_ovf,
  input wire logic time_base_tick,
  input wire logic rtc_tick
);
  import pcs_pkg::*;

  function automatic logic [4:0] lowest_set(input logic [4:0] v);
    lowest_set = v & (~v + 5'h01);
  endfunction

  function automatic logic [10:0] vector_of(input logic [4:0] g);
    vector_of = g[0] ? `PCS_VEC_EXT_A :
                g[1] ? `PCS_VEC_EXT_B :
                g[2] ? `PCS_VEC_TIMER :
                g[3] ? `PCS_VEC_TBASE :
                g[4] ? `PCS_VEC_RTC : `PCS_VEC_RESET;
  endfunction

  logic [10:0] instr_pointer;
  pcs_cyc_t cyc;
  logic [7:0] table_pointer;
  logic [7:0] table_high_byte;
  logic [2:0] tbl_page;
  logic [10:0] stack [0:3];
  logic [2:0] stack_index;
  logic [4:0] irq_flag;
  logic [4:0] irq_en;
  logic global_irq_enable;
  logic rd_ack;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [1:0] sync_fill;

  // decode of the executing command
  wire last = (phase == `PCS_PHASE_LAST);
  wire run_end = last && (cyc == CYC_RUN);
  wire pcs_op_t op = exec.valid ? cmd.op : OP_SEQ;
  wire is_jump = (op == OP_JUMP) || (op == OP_CALL);
  wire is_ret = (op == OP_RET) || (op == OP_RETI);
  wire is_skip = (op == OP_SKIP);
  wire is_tab = (op == OP_TAB_CUR) || (op == OP_TAB_LAST);

  // bus decode
  wire [3:0] idx = avs_address[5:2];
  wire wr_lane = avs_write && avs_byteenable[0];
  wire pcl_sel = wr_lane && (idx == `PCS_IDX_PC_LOW);
  wire pcl_ok = run_end && (op == OP_SEQ);
  wire pcl_go = pcl_sel && pcl_ok;
  wire ctrl_wr = wr_lane && (idx == `PCS_IDX_IRQ_CTRL);
  wire flag_wr = wr_lane && (idx == `PCS_IDX_IRQ_FLAG);
  wire ptr_wr = wr_lane && (idx == `PCS_IDX_TBL_PTR);

  // interrupt arbitration
  wire stack_full = (stack_index == `PCS_STACK_DEPTH);
  wire [4:0] pending = irq_flag & irq_en;
  wire [4:0] grant = lowest_set(pending);
  wire irq_take = run_end && (op == OP_SEQ) && !pcl_sel && global_irq_enable && (|pending)
    && !stack_full;
  wire [10:0] irq_vec = vector_of(grant);

  // external pins are edge triggered on either transition
  wire sync_ready = (sync_fill == 2'h3);
  wire ext_a_edge = sync_ready && (sync_a[2] ^ sync_a[1]);
  wire ext_b_edge = sync_ready && (sync_b[2] ^ sync_b[1]);
  wire [4:0] irq_set = {rtc_tick, time_base_tick, timer_ovf, ext_b_edge, ext_a_edge};
  wire [4:0] irq_clr_sw = flag_wr ? avs_writedata[4:0] : 5'h00;
  wire [4:0] irq_clr_hw = irq_take ? grant : 5'h00;
  // set wins over any clear in the same cycle
  wire [4:0] next_irq_flag = (irq_flag & ~irq_clr_sw & ~irq_clr_hw) | irq_set;

  // pointer load
  wire flush = is_jump || is_ret || is_skip || pcl_go || irq_take;
  wire do_push = run_end && ((op == OP_CALL) || irq_take);
  wire do_pop = run_end && is_ret;
  wire [10:0] next_pointer =
    is_jump ? cmd.target :
    is_ret ? stack[0] :
    pcl_go ? {exec.addr[10:8], avs_writedata[7:0]} :
    irq_take ? irq_vec :
    11'(instr_pointer + 11'h001);
  wire [10:0] tbl_addr = {tbl_page, table_pointer};
  wire [10:0] next_rom_addr = (cyc == CYC_TABLE) ? tbl_addr : instr_pointer;

  wire [7:0] reg_rd =
    (idx == `PCS_IDX_PC_LOW) ? instr_pointer[7:0] :
    (idx == `PCS_IDX_TBL_PTR) ? table_pointer :
    (idx == `PCS_IDX_TBL_HIGH) ? table_high_byte :
    (idx == `PCS_IDX_IRQ_CTRL) ? {global_irq_enable, 2'h0, irq_en} :
    (idx == `PCS_IDX_IRQ_FLAG) ? {3'h0, irq_flag} :
    (idx == `PCS_IDX_STACK) ? {5'h00, stack_index} : 8'h00;

  // low byte writes wait for a plain instruction boundary so they act as a branch
  assign avs_waitrequest = avs_read ? !rd_ack : (pcl_sel && !pcl_ok);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else begin
      phase <= 2'(phase + 2'h1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], ext_irq_a_pin};
      sync_b <= {sync_b[1:0], ext_irq_b_pin};
    end
  end

  // edges count only once the chain holds real pin samples: a pin idling high gives no false edge after reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_fill <= 2'h0;
    end else if (sync_fill != 2'h3) begin
      sync_fill <= 2'(sync_fill + 2'h1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rom_addr <= `PCS_VEC_RESET;
    end else begin
      rom_addr <= next_rom_addr;
    end
  end

  // pipeline: fetch lands in exec at the cycle boundary
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      instr_pointer <= `PCS_VEC_RESET;
      cyc <= CYC_RUN;
      exec <= '0;
      tbl_page <= 3'h0;
    end else if (run_end) begin
      exec.word <= rom_data;
      exec.addr <= instr_pointer;
      exec.valid <= !flush && !is_tab;
      instr_pointer <= next_pointer;
      if (is_tab) begin
        cyc <= CYC_TABLE;
        tbl_page <= (op == OP_TAB_LAST) ? `PCS_LAST_PAGE : exec.addr[10:8];
      end
    end else if (last) begin
      cyc <= CYC_RUN;
      exec.valid <= 1'b1;
    end
  end

  // table result: low byte to data memory, the rest to the high byte register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tbl_low_data <= 8'h00;
      tbl_low_we <= 1'b0;
      table_high_byte <= 8'h00;
    end else begin
      tbl_low_we <= last && (cyc == CYC_TABLE);
      if (last && (cyc == CYC_TABLE)) begin
        tbl_low_data <= rom_data[7:0];
        table_high_byte <= {2'h0, rom_data[13:8]};
      end
    end
  end

  // return stack as a shift register; a push when full drops the oldest entry
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stack_index <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        stack[i] <= 11'h000;
      end
    end else if (do_push) begin
      stack[0] <= instr_pointer;
      for (int i = 1; i < 4; i++) begin
        stack[i] <= stack[i-1];
      end
      if (!stack_full) begin
        stack_index <= 3'(stack_index + 3'h1);
      end
    end else if (do_pop) begin
      for (int i = 0; i < 3; i++) begin
        stack[i] <= stack[i+1];
      end
      stack[3] <= 11'h000;
      if (stack_index != 3'h0) begin
        stack_index <= 3'(stack_index - 3'h1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_flag <= `PCS_RESET_IRQ;
      irq_en <= `PCS_RESET_IRQ;
      global_irq_enable <= 1'b0;
    end else begin
      irq_flag <= next_irq_flag;
      if (ctrl_wr) begin
        irq_en <= avs_writedata[4:0];
      end
      if (irq_take) begin
        global_irq_enable <= 1'b0;
      end else if (run_end && (op == OP_RETI)) begin
        global_irq_enable <= 1'b1;
      end else if (ctrl_wr) begin
        global_irq_enable <= avs_writedata[`PCS_GIE_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      table_pointer <= 8'h00;
    end else if (ptr_wr) begin
      table_pointer <= avs_writedata[7:0];
    end
  end

  // reads answer one cycle after the request; the high byte register ignores writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        avs_readdata <= {24'h000000, reg_rd};
      end
    end
  end

  a_phase_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    (phase == 2'h3) |=> (phase == 2'h0) ##1 (phase == 2'h1))
    else $error("phase counter did not wrap after four clocks");


  a_pointer_moment: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(instr_pointer) |-> ($past(phase) == 2'h3))
    else $error("pointer moved away from a cycle boundary");


  a_seq_incr: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && !flush) |=> (instr_pointer == 11'($past(instr_pointer) + 11'h001)) && exec.valid == !$past(is_tab))
    else $error("pointer did not step by one");


  a_jump_load: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && is_jump) |=> (instr_pointer == $past(cmd.target)) && !exec.valid)
    else $error("jump did not load target with a dummy cycle");


  a_skip_flush: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && is_skip) |=> !exec.valid && (instr_pointer == 11'($past(exec.addr) + 11'h002)))
    else $error("skip did not discard and advance by two");


  a_pcl_page: assert property (@(posedge mclk) disable iff (!nrst)
    pcl_go |=> (instr_pointer[10:8] == $past(exec.addr[10:8])) && (instr_pointer[7:0] == $past(avs_writedata[7:0]))
      && !exec.valid)
    else $error("low byte write did not jump inside the page");


  a_irq_vector: assert property (@(posedge mclk) disable iff (!nrst)
    irq_take |=> (instr_pointer == $past(irq_vec)) && !global_irq_enable && (stack[0] == $past(instr_pointer)))
    else $error("interrupt did not vector and push");


  a_irq_full: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && stack_full && !is_ret && global_irq_enable && (|pending) && !flag_wr)
      |=> ((irq_flag & $past(pending)) == $past(pending)) && stack_full)
    else $error("request lost or taken while the stack was full");


  a_lowest_first: assert property (@(posedge mclk) disable iff (!nrst)
    irq_take |-> ((5'(grant - 5'h01) & pending) == 5'h00) && $onehot(grant))
    else $error("interrupt priority not lowest vector first");


  a_table_len: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && is_tab) |=> (cyc == CYC_TABLE)[*4] ##1 (cyc == CYC_RUN) && tbl_low_we && exec.valid)
    else $error("table read did not take two cycles");


  a_table_high_byte_upper: assert property (@(posedge mclk) disable iff (!nrst)
    tbl_low_we |-> (table_high_byte == {2'h0, $past(rom_data[13:8])}))
    else $error("table high byte wrong");

  // returns, table paths, interrupt entry, stack and bus; table fetch and low byte stall checked in the same clock, the rest one clock after the edge that acts
  a_ret_pop: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && is_ret) |=> (instr_pointer == $past(stack[0])) && !exec.valid)
    else $error("return did not reload the stack top with a dummy cycle");

  a_table_page: assert property (@(posedge mclk) disable iff (!nrst)
    (run_end && is_tab) |=> (tbl_page == (($past(op) == OP_TAB_LAST) ? `PCS_LAST_PAGE : $past(exec.addr[10:8]))))
    else $error("table page taken from the wrong source");

  a_tab_fetch: assert property (@(posedge mclk) disable iff (!nrst)
    ((cyc == CYC_TABLE) && (phase == 2'h2)) |-> (rom_addr == {tbl_page, $past(table_pointer)}))
    else $error("table cycle did not address the table location");

  a_flag_clear: assert property (@(posedge mclk) disable iff (!nrst)
    irq_take |=> ((irq_flag & $past(grant & ~irq_set)) == 5'h00) && !global_irq_enable)
    else $error("vectoring left the request flag or global enable set");

  a_vector_map: assert property (@(posedge mclk) disable iff (!nrst)
    irq_take |=> (!$past(grant[0]) || (instr_pointer == `PCS_VEC_EXT_A))
      && (!$past(grant[1]) || (instr_pointer == `PCS_VEC_EXT_B))
      && (!$past(grant[2]) || (instr_pointer == `PCS_VEC_TIMER))
      && (!$past(grant[3]) || (instr_pointer == `PCS_VEC_TBASE))
      && (!$past(grant[4]) || (instr_pointer == `PCS_VEC_RTC)))
    else $error("vector does not match the granted source");

  a_stack_push: assert property (@(posedge mclk) disable iff (!nrst)
    (do_push && !stack_full) |=> (stack_index == 3'($past(stack_index) + 3'h1)))
    else $error("push did not grow the stack");

  a_pcl_stall: assert property (@(posedge mclk) disable iff (!nrst)
    (pcl_sel && !run_end) |-> avs_waitrequest)
    else $error("low byte write accepted away from a cycle boundary");

  a_read_answer: assert property (@(posedge mclk) disable iff (!nrst)
    (avs_read && !rd_ack) |=> (!avs_read || !avs_waitrequest))
    else $error("read not answered one clock after the request");
endmodule
`default_nettype wire

// ---- pkg/pcs_params.svh ----
// constants for the program counter sequencer: register indices, vectors, fields
// assumes inclusion by the package, the design file and the bench, bare name
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
// register indices; byte address is four times the index
`define PCS_IDX_PC_LOW 4'h6
`define PCS_IDX_TBL_PTR 4'h7
`define PCS_IDX_TBL_HIGH 4'h8
`define PCS_IDX_IRQ_CTRL 4'h9
`define PCS_IDX_IRQ_FLAG 4'hc
`define PCS_IDX_STACK 4'hd
// program counter loads
`define PCS_VEC_RESET 11'h000
`define PCS_VEC_EXT_A 11'h004
`define PCS_VEC_EXT_B 11'h008
`define PCS_VEC_TIMER 11'h00c
`define PCS_VEC_TBASE 11'h010
`define PCS_VEC_RTC 11'h014
`define PCS_LAST_PAGE 3'h7
// instruction cycle and stack
`define PCS_PHASE_LAST 2'h3
`define PCS_STACK_DEPTH 3'h4
// irq control fields
`define PCS_GIE_BIT 7
`define PCS_IRQ_N 5
`define PCS_RESET_IRQ 5'h00
`endif

// ---- pkg/pcs_pkg.sv ----
// types shared by the sequencer and its bench
// assumes pcs_params.svh on the include path
`default_nettype none
`include "pcs_params.svh"
package pcs_pkg;
  typedef enum logic [2:0] {
    OP_SEQ, OP_JUMP, OP_CALL, OP_RET, OP_RETI, OP_SKIP, OP_TAB_CUR, OP_TAB_LAST
  } pcs_op_t;
  typedef struct packed {
    pcs_op_t op;
    logic [10:0] target;
  } pcs_cmd_t;
  typedef struct packed {
    logic valid;
    logic [10:0] addr;
    logic [13:0] word;
  } pcs_exec_t;
  typedef enum logic {CYC_RUN, CYC_TABLE} pcs_cyc_t;
endpackage
`default_nettype wire
